// file: stack_config_checker_params.svh
`ifndef STACK_CONFIG_CHECKER_PARAMS_SVH
`define STACK_CONFIG_CHECKER_PARAMS_SVH

// ============================================================
// Register map (APB byte addresses).
`define SCC_ADDR_CTRL 12'h000
`define SCC_ADDR_STATUS 12'h004
`define SCC_ADDR_IRQ_STATUS 12'h008
`define SCC_ADDR_IRQ_MASK 12'h00C
`define SCC_ADDR_W 12

// ============================================================
// Control register fields.
`define SCC_CTRL_HOST_TYPE2_BIT 0
`define SCC_CTRL_START_BIT 1
`define SCC_CTRL_RESET 32'h0000_0000

// ============================================================
// Status register fields.
`define SCC_STAT_ERROR_BIT 0
`define SCC_STAT_X16_BIT 1
`define SCC_STAT_GFX_BIT 2
`define SCC_STAT_DONE_BIT 3
`define SCC_STAT_SENSE_LSB 4

// ============================================================
// Interrupt bits.
`define SCC_IRQ_ERROR_BIT 0
`define SCC_IRQ_DONE_BIT 1
`define SCC_IRQ_W 2
`define SCC_IRQ_RESET 2'h0

// ============================================================
// Timing: settling time before sampling, in ns, at 50 MHz.
`define SCC_SETTLE_NS 1000
`define SCC_CLK_NS 20
`define SCC_SETTLE_CYCLES ((`SCC_SETTLE_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_CNT_W 8

`endif

// file: stack_config_checker_pkg.sv
package stack_config_checker_pkg;

  // Checker sequence states.
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_DECIDE = 2'b01,
    ST_RUN = 2'b10,
    ST_FAULT = 2'b11
  } chk_state_t;

  // Three stacking-sense lines.
  typedef struct packed {
    logic stack_sense_2_video_data;
    logic stack_sense_1_graphics_lane_select;
    logic stack_sense_0_wake_line;
  } sense_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer to the master.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Whole state of the checker.
  typedef struct packed {
    chk_state_t st;
    logic [7:0] cnt;
    logic host_type2;
    logic start;
    logic err;
    logic x16;
    logic alternate_graphics_function;
    logic done;
    sense_t snap;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] prdata;
    logic pslverr;
  } chk_reg_t;

endpackage

// file: stack_config_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "stack_config_checker_params.svh"

module stack_config_checker (
  // Clock and power-on reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // APB slave.
  input wire stack_config_checker_pkg::apb_req_t apb_i,
  output stack_config_checker_pkg::apb_rsp_t apb_o,
  // Stacking-sense lines, inputs only.
  input wire stack_config_checker_pkg::sense_t sense_i,
  // System reset hold and decode results.
  output logic system_reset_hold_o,
  output logic stacking_error_o,
  output logic express_x16_enable_o,
  output logic alternate_graphics_function_o,
  // Output enables for the guarded signal groups.
  output logic serial_ata_oe_o,
  output logic low_pin_count_oe_o,
  // Interrupt.
  output logic irq_o
);
  import stack_config_checker_pkg::*;

  chk_reg_t r;
  chk_reg_t next_r;
  logic wr_en;
  logic rd_en;
  logic type1_err;
  logic type2_err;
  logic dec_err;
  logic [1:0] irq_set;

  // ============================================================
  // Decode of the sense lines.

  // Type 1 error comes only from sense line 0.
  // line 0 low
  assign type1_err = ~sense_i.stack_sense_0_wake_line;
  // line 1 low or line 2 high
  assign type2_err = ~sense_i.stack_sense_1_graphics_lane_select |
                     sense_i.stack_sense_2_video_data;
  assign dec_err = r.host_type2 ? type2_err : type1_err;

  // APB strobes: write in the access phase, read in the setup phase; the slave answers with no wait state.
  assign wr_en = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign rd_en = apb_i.psel & ~apb_i.penable & ~apb_i.pwrite;

  // ============================================================
  // Next-state logic.

  // Sequence, register writes and read data.
  always_comb begin
    next_r = r;
    irq_set = `SCC_IRQ_RESET;
    case (r.st)
      ST_SETTLE: begin
        if (r.start && r.cnt != 8'h00) begin
          next_r.cnt = r.cnt - 8'h01;
        end
        if (r.start && r.cnt == 8'h00) begin
          next_r.st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        next_r.snap = sense_i;
        next_r.done = 1'b1;
        irq_set[`SCC_IRQ_DONE_BIT] = 1'b1;
        if (dec_err) begin
          next_r.err = 1'b1;
          irq_set[`SCC_IRQ_ERROR_BIT] = 1'b1;
          next_r.st = ST_FAULT;
        end else begin
          next_r.st = ST_RUN;
          if (!r.host_type2) begin
            next_r.x16 = ~sense_i.stack_sense_1_graphics_lane_select |
                         ~sense_i.stack_sense_2_video_data;
            next_r.alternate_graphics_function = sense_i.stack_sense_1_graphics_lane_select &
                         sense_i.stack_sense_2_video_data;
          end
        end
      end
      ST_RUN: begin
        next_r.st = ST_RUN;
      end
      default: begin
        next_r.st = ST_FAULT;
      end
    endcase

    // Writes: control only before a decision, interrupt regs any time.
    if (wr_en) begin
      if (apb_i.paddr == `SCC_ADDR_CTRL) begin
        if (r.st == ST_SETTLE) begin
          next_r.host_type2 = apb_i.pwdata[`SCC_CTRL_HOST_TYPE2_BIT];
          next_r.start = apb_i.pwdata[`SCC_CTRL_START_BIT];
        end
      end else if (apb_i.paddr == `SCC_ADDR_IRQ_STATUS) begin
        next_r.irq_status = r.irq_status &
                            ~apb_i.pwdata[`SCC_IRQ_W-1:0];
      end else if (apb_i.paddr == `SCC_ADDR_IRQ_MASK) begin
        next_r.irq_mask = apb_i.pwdata[`SCC_IRQ_W-1:0];
      end
    end
    // New events win over a clear in the same cycle.
    next_r.irq_status = next_r.irq_status | irq_set;

    // Read data is registered during the setup phase.
    next_r.pslverr = 1'b0;
    if (rd_en) begin
      next_r.prdata = 32'h0000_0000;
      if (apb_i.paddr == `SCC_ADDR_CTRL) begin
        next_r.prdata[`SCC_CTRL_HOST_TYPE2_BIT] = r.host_type2;
        next_r.prdata[`SCC_CTRL_START_BIT] = r.start;
      end else if (apb_i.paddr == `SCC_ADDR_STATUS) begin
        next_r.prdata[`SCC_STAT_ERROR_BIT] = r.err;
        next_r.prdata[`SCC_STAT_X16_BIT] = r.x16;
        next_r.prdata[`SCC_STAT_GFX_BIT] = r.alternate_graphics_function;
        next_r.prdata[`SCC_STAT_DONE_BIT] = r.done;
        next_r.prdata[`SCC_STAT_SENSE_LSB+2:`SCC_STAT_SENSE_LSB] = r.snap;
      end else if (apb_i.paddr == `SCC_ADDR_IRQ_STATUS) begin
        next_r.prdata[`SCC_IRQ_W-1:0] = r.irq_status;
      end else if (apb_i.paddr == `SCC_ADDR_IRQ_MASK) begin
        next_r.prdata[`SCC_IRQ_W-1:0] = r.irq_mask;
      end else begin
        next_r.pslverr = 1'b1;
      end
    end else if (apb_i.psel & ~apb_i.penable) begin
      // Unmapped write addresses answer with an error.
      next_r.pslverr = ~(apb_i.paddr == `SCC_ADDR_CTRL ||
                         apb_i.paddr == `SCC_ADDR_STATUS ||
                         apb_i.paddr == `SCC_ADDR_IRQ_STATUS ||
                         apb_i.paddr == `SCC_ADDR_IRQ_MASK);
    end
  end

  // ============================================================
  // State register.

  // Power-on reset restarts the whole check.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      r.st <= ST_SETTLE;
      r.cnt <= `SCC_CNT_W'(`SCC_SETTLE_CYCLES);
      r.host_type2 <= 1'b0;
      r.start <= 1'b0;
      r.err <= 1'b0;
      r.x16 <= 1'b0;
      r.alternate_graphics_function <= 1'b0;
      r.done <= 1'b0;
      r.snap <= 3'h0;
      r.irq_status <= `SCC_IRQ_RESET;
      r.irq_mask <= `SCC_IRQ_RESET;
      r.prdata <= 32'h0000_0000;
      r.pslverr <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ============================================================
  // Outputs.

  // Reset is held until a clean decision; a fault holds it forever.
  // hold on error
  assign system_reset_hold_o = (r.st != ST_RUN);
  assign stacking_error_o = r.err;
  assign express_x16_enable_o = r.x16;
  assign alternate_graphics_function_o = r.alternate_graphics_function;
  assign serial_ata_oe_o = (r.st == ST_RUN);
  assign low_pin_count_oe_o = (r.st == ST_RUN);
  // Unmasked sticky events raise the interrupt.
  assign irq_o = |(r.irq_status & r.irq_mask);

  // APB answer; read data was registered in the setup cycle.
  assign apb_o.pready = 1'b1;
  assign apb_o.pslverr = r.pslverr & apb_i.psel & apb_i.penable;
  assign apb_o.prdata = r.prdata;

  // sense lines are inputs only, no enable exists for them.

endmodule
`default_nettype wire

// file: stack_config_checker_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker of the stacking outputs.
module stack_config_checker_props (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Watched ports.
  input wire stack_config_checker_pkg::apb_req_t apb_i,
  input wire stack_config_checker_pkg::apb_rsp_t apb_o,
  input wire stack_config_checker_pkg::sense_t sense_i,
  input wire logic system_reset_hold_o,
  input wire logic stacking_error_o,
  input wire logic express_x16_enable_o,
  input wire logic alternate_graphics_function_o,
  input wire logic serial_ata_oe_o,
  input wire logic low_pin_count_oe_o,
  input wire logic irq_o
);
  import stack_config_checker_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_err_holds: assert property (stacking_error_o |-> system_reset_hold_o)
    else $error("Error seen without reset hold.");
  a_oe_err: assert property (stacking_error_o |-> !serial_ata_oe_o)
    else $error("Guarded group driven during error.");
  a_oe_hold: assert property (serial_ata_oe_o == !system_reset_hold_o)
    else $error("Group enable not tied to reset hold.");
  a_oe_pair: assert property (serial_ata_oe_o == low_pin_count_oe_o)
    else $error("Guarded group enables differ.");
  a_err_sticky: assert property (stacking_error_o |=> stacking_error_o)
    else $error("Error flag dropped.");
  a_hold_once: assert property (!$rose(system_reset_hold_o))
    else $error("Reset hold rose outside reset.");
  a_run_stays: assert property (!system_reset_hold_o |=>
    !system_reset_hold_o && !stacking_error_o)
    else $error("Run state left.");
  a_err_mode: assert property (stacking_error_o |->
    !express_x16_enable_o && !alternate_graphics_function_o)
    else $error("Mode enabled with error.");
  a_x16_dec: assert property ($rose(express_x16_enable_o) |->
    !sense_i[1] || !sense_i[2])
    else $error("Wide link enabled on wrong sense.");
  a_gfx_dec: assert property ($rose(alternate_graphics_function_o) |->
    sense_i[1] && sense_i[2] && !express_x16_enable_o)
    else $error("Graphics enabled on wrong sense.");
endmodule

bind stack_config_checker stack_config_checker_props u_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o),
  .sense_i(sense_i), .system_reset_hold_o(system_reset_hold_o),
  .stacking_error_o(stacking_error_o), .irq_o(irq_o),
  .express_x16_enable_o(express_x16_enable_o),
  .alternate_graphics_function_o(alternate_graphics_function_o),
  .serial_ata_oe_o(serial_ata_oe_o), .low_pin_count_oe_o(low_pin_count_oe_o));
`default_nettype wire

// file: stack_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Stacked peripherals and host biasing on the sense lines.
module stack_peer_model (
  // Peripheral mix.
  input wire logic short_wake_i,
  input wire logic short_lane_i,
  input wire logic pullup_video_i,
  // Resolved sense lines.
  output var stack_config_checker_pkg::sense_t sense_o
);
  import stack_config_checker_pkg::*;
  // The modelled peers drive no guarded group while the link is reset.
  // Each peer is modelled as sitting on whichever side faces the host.
  // Link shifting is outside the sense lines, so only levels are shown.
  // wake floats in reset, so the host pull-up wins.
  assign sense_o.stack_sense_0_wake_line = !short_wake_i;
  // lane line is pulled up unless a wide-link card shorts it.
  assign sense_o.stack_sense_1_graphics_lane_select = !short_lane_i;
  // video line is pulled down unless a graphics card pulls it up.
  assign sense_o.stack_sense_2_video_data = pullup_video_i;
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "stack_config_checker_params.svh"
// ==========
// Testbench.
module tb;
  import stack_config_checker_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  apb_req_t apb_i = '0;
  apb_rsp_t apb_o;
  sense_t sense_i;
  logic hold, err, x16, alternate_graphics_function, sata_oe, lpc_oe, irq, serr;
  logic s_wake = 1'b0, s_lane = 1'b0, p_video = 1'b0;
  logic [31:0] rd;
  int n_errors = 0, num_checks = 0, cyc = 0;
  // Type2, wake short, lane short, video pull-up, error, x16, graphics.
  logic [6:0] rows [8] = '{7'h02, 7'h12, 7'h09, 7'h24,
                           7'h60, 7'h54, 7'h4C, 7'h40};
  stack_config_checker u_stack_config_checker (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .apb_i(apb_i), .apb_o(apb_o), .sense_i(sense_i),
    .system_reset_hold_o(hold), .stacking_error_o(err),
    .express_x16_enable_o(x16), .alternate_graphics_function_o(alternate_graphics_function),
    .serial_ata_oe_o(sata_oe), .low_pin_count_oe_o(lpc_oe), .irq_o(irq));
  stack_peer_model u_stack_peer_model (.short_wake_i(s_wake),
    .short_lane_i(s_lane), .pullup_video_i(p_video), .sense_o(sense_i));
  // Clock and hang guard.
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task test_done();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; read data and error taken at the access edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_i);
    apb_i.penable <= 1'b1;
    do @(posedge clk_sys_i); while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    serr = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask
  // Reset with one peripheral mix, start the check, wait for a verdict.
  task run(input logic [6:0] r);
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    s_wake <= r[5];
    s_lane <= r[4];
    p_video <= r[3];
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(1'b1, `SCC_ADDR_CTRL, {30'h0, 1'b1, r[6]});
    chk("settle", {30'h0, hold, sata_oe}, 32'h2);
    for (int i = 0; i < 200 && hold === 1'b1 && err !== 1'b1; i++)
      @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    chk("decode", {29'h0, err, x16, alternate_graphics_function}, {29'h0, r[2:0]});
    chk("hold", {31'h0, hold}, {31'h0, r[2]});
    chk("oe", {30'h0, sata_oe, lpc_oe}, {30'h0, {2{!r[2]}}});
  endtask
  // Table loop, then interrupts, refused writes and an unmapped place.
  initial begin
    foreach (rows[k]) run(rows[k]);
    run(7'h24);
    apb(1'b0, `SCC_ADDR_IRQ_STATUS, 32'h0);
    chk("irq_status", rd, 32'h3);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `SCC_ADDR_IRQ_MASK, 32'h1);
    @(posedge clk_sys_i);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, `SCC_ADDR_IRQ_STATUS, 32'h1);
    @(posedge clk_sys_i);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    apb(1'b1, `SCC_ADDR_STATUS, 32'h0);
    apb(1'b1, `SCC_ADDR_CTRL, 32'h2);
    apb(1'b0, `SCC_ADDR_STATUS, 32'h0);
    chk("sticky", rd & 32'hF, 32'h9);
    chk("hold_kept", {31'h0, hold}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {serr, rd[30:0]}, 32'h80000000);
    test_done();
  end
endmodule
`default_nettype wire
